// ---- verilog/mra_pkg.sv ----
`default_nettype none
package mra_pkg;
	// ************************************************************
	// Register pointers
	// ************************************************************
	localparam logic [7:0] ADDR_BUS_VOLTAGE_RESULT = 8'h02;
	localparam logic [7:0] ADDR_POWER_RESULT       = 8'h03;
	localparam logic [7:0] ADDR_CURRENT_RESULT     = 8'h04;
	localparam logic [7:0] ADDR_CALIBRATION_VALUE  = 8'h05;
	localparam logic [7:0] ADDR_ALERT_MASK_FLAGS   = 8'h06;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] RST_RESULT      = 16'h0000;
	localparam logic [15:0] RST_CALIBRATION = 16'h0000;
	localparam logic [15:0] RST_MASK        = 16'h0000;

	// ************************************************************
	// Mask/flag register fields
	// ************************************************************
	localparam int BIT_SHUNT_OVER  = 15;
	localparam int BIT_SHUNT_UNDER = 14;
	localparam int BIT_BUS_OVER    = 13;
	localparam int BIT_BUS_UNDER   = 12;
	localparam int BIT_POWER_OVER  = 11;
	localparam int BIT_READY_ALERT = 10;
	localparam int BIT_ALERT_FLAG  = 4;
	localparam int BIT_DONE_FLAG   = 3;
	localparam int BIT_OVERFLOW    = 2;
	localparam int BIT_POLARITY    = 1;
	localparam int BIT_LATCH       = 0;
	localparam logic [15:0] MASK_WR_BITS = 16'hfc03;
	localparam logic [15:0] CAL_WR_BITS  = 16'h7fff;

	// ************************************************************
	// Arithmetic scaling
	// ************************************************************
	// Current = shunt * calibration / 2048
	localparam int CURRENT_SHIFT = 11;
	// Power step is 25 current steps: current * bus / 20000
	localparam logic [31:0] POWER_DIVISOR = 32'h00004e20;
	localparam logic [15:0] FULL_SCALE_POS = 16'h7fff;
	localparam logic [15:0] FULL_SCALE_NEG = 16'h8000;
	localparam logic [3:0]  MAX_AVG_LOG2   = 4'ha;
	localparam int          AVG_ACC_W      = 26;
	localparam logic [9:0]  AVG_CNT_RST    = 10'h000;
endpackage : mra_pkg
`default_nettype wire

// ---- verilog/mra_avg_if.sv ----
`default_nettype none
interface mra_avg_if;
	logic        sample_valid;
	logic [15:0] shunt_sample;
	logic [15:0] bus_sample;
	logic [3:0]  avg_log2;
	logic        avg_done;
	logic [15:0] shunt_avg;
	logic [15:0] bus_avg;

	modport requester (
		output sample_valid, shunt_sample, bus_sample, avg_log2,
		input  avg_done, shunt_avg, bus_avg
	);
	modport averager (
		input  sample_valid, shunt_sample, bus_sample, avg_log2,
		output avg_done, shunt_avg, bus_avg
	);
endinterface : mra_avg_if
`default_nettype wire

// ---- verilog/mra_averager.sv ----
`default_nettype none
module mra_averager (
	input  wire logic   i_sys_clk,
	input  wire logic   i_resetn,
	input  wire logic   i_clk_en,
	mra_avg_if.averager avg
);
	localparam int W = mra_pkg::AVG_ACC_W;

	logic signed [W-1:0] shunt_acc_reg;
	logic        [W-1:0] bus_acc_reg;
	logic        [9:0]   count_reg;
	logic        [3:0]   log2_eff;
	logic        [9:0]   last_count;
	logic signed [W-1:0] shunt_sum;
	logic        [W-1:0] bus_sum;

	// ************************************************************
	// Window length, clamped so the accumulator cannot wrap
	// ************************************************************
	assign log2_eff = (avg.avg_log2 > mra_pkg::MAX_AVG_LOG2) ?
		mra_pkg::MAX_AVG_LOG2 : avg.avg_log2;
	assign last_count = 10'((11'h001 << log2_eff) - 11'h001);
	assign shunt_sum  = shunt_acc_reg +
		W'(signed'(avg.shunt_sample));
	assign bus_sum    = bus_acc_reg + W'(avg.bus_sample);

	// Averaged value replaces the single sample
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			shunt_acc_reg <= '0;
			bus_acc_reg   <= '0;
			count_reg     <= mra_pkg::AVG_CNT_RST;
			avg.avg_done  <= 1'b0;
			avg.shunt_avg <= mra_pkg::RST_RESULT;
			avg.bus_avg   <= mra_pkg::RST_RESULT;
		end else if (i_clk_en) begin
			avg.avg_done <= 1'b0;
			if (avg.sample_valid) begin
				if (count_reg >= last_count) begin
					shunt_acc_reg <= '0;
					bus_acc_reg   <= '0;
					count_reg     <= mra_pkg::AVG_CNT_RST;
					avg.avg_done  <= 1'b1;
					avg.shunt_avg <= 16'(shunt_sum >>> log2_eff);
					avg.bus_avg   <= 16'(bus_sum >> log2_eff);
				end else begin
					shunt_acc_reg <= shunt_sum;
					bus_acc_reg   <= bus_sum;
					count_reg     <= count_reg + 10'h001;
				end
			end
		end
	end
endmodule : mra_averager
`default_nettype wire

// ---- verilog/mra_result_alert_regs.sv ----
`default_nettype none
module mra_result_alert_regs (
	input  wire logic        i_sys_clk,
	input  wire logic        i_resetn,
	input  wire logic        i_clk_en,
	input  wire logic [7:0]  i_reg_ptr,
	input  wire logic        i_reg_wr_en,
	input  wire logic        i_reg_rd_en,
	input  wire logic [15:0] i_reg_wdata,
	output var  logic [15:0] o_reg_rdata,
	output var  logic        o_reg_rvalid,
	input  wire logic        i_cfg_write,
	input  wire logic        i_cfg_powerdown,
	input  wire logic [15:0] i_alert_limit,
	input  wire logic [3:0]  i_avg_log2,
	input  wire logic        i_sample_valid,
	input  wire logic [15:0] i_shunt_sample,
	input  wire logic [15:0] i_bus_sample,
	input  wire logic        i_alert_pin,
	output var  logic        o_alert_out,
	output var  logic        o_alert_oe
);
	typedef enum logic [1:0] {
		ST_IDLE, ST_CURRENT, ST_POWER, ST_COMPARE
	} mra_state_t;

	mra_state_t          state_reg;
	logic [15:0]         bus_voltage_result_reg;
	logic [15:0]         power_result_reg;
	logic [15:0]         current_result_reg;
	logic [15:0]         calibration_value_reg;
	logic [15:0]         mask_reg;
	logic signed [15:0]  shunt_hold_reg;
	logic                alert_function_flag_reg;
	logic                conversion_done_flag_reg;
	logic                math_overflow_flag_reg;
	logic                cur_ovf_reg;
	logic                mask_read;
	logic                cfg_clear;
	logic                limit_hit;
	logic                any_func;
	logic                alert_active;
	logic signed [31:0]  cur_product;
	logic signed [31:0]  cur_scaled;
	logic [15:0]         cur_magnitude;
	logic [31:0]         pwr_product;
	logic [31:0]         pwr_scaled;

	mra_avg_if avg_bus ();

	assign avg_bus.sample_valid = i_sample_valid;
	assign avg_bus.shunt_sample = i_shunt_sample;
	assign avg_bus.bus_sample   = i_bus_sample;
	assign avg_bus.avg_log2     = i_avg_log2;

	mra_averager u_averager (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_clk_en  (i_clk_en),
		.avg       (avg_bus.averager)
	);

	// ************************************************************
	// Decoding shared by writes and flag clears
	// ************************************************************
	function automatic logic is_ptr(input logic [7:0] p,
		input logic [7:0] a);
		return p == a;
	endfunction : is_ptr

	assign mask_read = i_reg_rd_en &&
		is_ptr(i_reg_ptr, mra_pkg::ADDR_ALERT_MASK_FLAGS);
	// Powering down leaves the last result flagged as ready
	assign cfg_clear = i_cfg_write && !i_cfg_powerdown;

	// ************************************************************
	// Arithmetic
	// ************************************************************
	assign cur_product = shunt_hold_reg *
		signed'({17'h00000, calibration_value_reg[14:0]});
	assign cur_scaled  = cur_product >>> mra_pkg::CURRENT_SHIFT;
	assign cur_magnitude = current_result_reg[15] ?
		16'(-current_result_reg) : current_result_reg;
	// Dividing by the constant keeps one power step at 25 current steps
	assign pwr_product = {16'h0000, cur_magnitude} *
		{16'h0000, bus_voltage_result_reg};
	assign pwr_scaled  = pwr_product / mra_pkg::POWER_DIVISOR;

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= ST_IDLE;
		end else if (i_clk_en) begin
			case (state_reg)
				ST_IDLE: begin
					if (avg_bus.avg_done) begin
						state_reg <= ST_CURRENT;
					end
				end
				ST_CURRENT: state_reg <= ST_POWER;
				ST_POWER:   state_reg <= ST_COMPARE;
				ST_COMPARE: state_reg <= ST_IDLE;
				default:    state_reg <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Result registers
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			bus_voltage_result_reg <= mra_pkg::RST_RESULT;
			shunt_hold_reg         <= signed'(mra_pkg::RST_RESULT);
		end else if (i_clk_en && state_reg == ST_IDLE &&
			avg_bus.avg_done) begin
			shunt_hold_reg <= signed'(avg_bus.shunt_avg);
			// Top bit can never be set; saturate at full scale
			if (avg_bus.bus_avg[15]) begin
				bus_voltage_result_reg <= mra_pkg::FULL_SCALE_POS;
			end else begin
				bus_voltage_result_reg <= avg_bus.bus_avg;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			current_result_reg <= mra_pkg::RST_RESULT;
			cur_ovf_reg        <= 1'b0;
		end else if (i_clk_en && state_reg == ST_CURRENT) begin
			if (cur_scaled > 32'sh00007fff) begin
				current_result_reg <= mra_pkg::FULL_SCALE_POS;
				cur_ovf_reg        <= 1'b1;
			end else if (cur_scaled < -32'sh00008000) begin
				current_result_reg <= mra_pkg::FULL_SCALE_NEG;
				cur_ovf_reg        <= 1'b1;
			end else begin
				current_result_reg <= 16'(cur_scaled);
				cur_ovf_reg        <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			power_result_reg       <= mra_pkg::RST_RESULT;
			math_overflow_flag_reg <= 1'b0;
		end else if (i_clk_en && state_reg == ST_POWER) begin
			if (pwr_scaled > 32'h0000ffff) begin
				power_result_reg       <= 16'hffff;
				math_overflow_flag_reg <= 1'b1;
			end else begin
				power_result_reg       <= pwr_scaled[15:0];
				math_overflow_flag_reg <= cur_ovf_reg;
			end
		end
	end

	// ************************************************************
	// Host-written registers
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			calibration_value_reg <= mra_pkg::RST_CALIBRATION;
			mask_reg              <= mra_pkg::RST_MASK;
		end else if (i_clk_en && i_reg_wr_en) begin
			if (is_ptr(i_reg_ptr, mra_pkg::ADDR_CALIBRATION_VALUE)) begin
				calibration_value_reg <=
					i_reg_wdata & mra_pkg::CAL_WR_BITS;
			end
			if (is_ptr(i_reg_ptr, mra_pkg::ADDR_ALERT_MASK_FLAGS)) begin
				mask_reg <= i_reg_wdata & mra_pkg::MASK_WR_BITS;
			end
		end
	end

	// ************************************************************
	// Limit comparison, highest enabled function only
	// ************************************************************
	always_comb begin
		limit_hit = 1'b0;
		any_func  = 1'b1;
		if (mask_reg[mra_pkg::BIT_SHUNT_OVER]) begin
			limit_hit = shunt_hold_reg >
				signed'(i_alert_limit);
		end else if (mask_reg[mra_pkg::BIT_SHUNT_UNDER]) begin
			limit_hit = shunt_hold_reg <
				signed'(i_alert_limit);
		end else if (mask_reg[mra_pkg::BIT_BUS_OVER]) begin
			limit_hit = bus_voltage_result_reg > i_alert_limit;
		end else if (mask_reg[mra_pkg::BIT_BUS_UNDER]) begin
			limit_hit = bus_voltage_result_reg < i_alert_limit;
		end else if (mask_reg[mra_pkg::BIT_POWER_OVER]) begin
			limit_hit = power_result_reg > i_alert_limit;
		end else begin
			any_func = 1'b0;
		end
	end

	// ************************************************************
	// Flags; a setting event wins over a clearing one
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			conversion_done_flag_reg <= 1'b0;
		end else if (i_clk_en) begin
			if (state_reg == ST_COMPARE) begin
				conversion_done_flag_reg <= 1'b1;
			end else if (cfg_clear || mask_read) begin
				conversion_done_flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			alert_function_flag_reg <= 1'b0;
		end else if (i_clk_en) begin
			if (mask_reg[mra_pkg::BIT_LATCH]) begin
				if (state_reg == ST_COMPARE && limit_hit) begin
					alert_function_flag_reg <= 1'b1;
				end else if (mask_read) begin
					alert_function_flag_reg <= 1'b0;
				end
			end else if (state_reg == ST_COMPARE) begin
				alert_function_flag_reg <= limit_hit;
			end
		end
	end

	// ************************************************************
	// Alert pin, open collector
	// ************************************************************
	// Pin level is not read back; the host sees state in the flags
	assign alert_active = (alert_function_flag_reg && any_func) ||
		(mask_reg[mra_pkg::BIT_READY_ALERT] &&
		conversion_done_flag_reg);

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_alert_oe  <= 1'b0;
			o_alert_out <= 1'b0;
		end else if (i_clk_en) begin
			// Pulling low means asserted only for the normal polarity
			o_alert_oe  <= alert_active ^
				mask_reg[mra_pkg::BIT_POLARITY];
			o_alert_out <= 1'b0;
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reg_rdata  <= mra_pkg::RST_RESULT;
			o_reg_rvalid <= 1'b0;
		end else if (i_clk_en) begin
			o_reg_rvalid <= i_reg_rd_en;
			if (i_reg_rd_en) begin
				case (i_reg_ptr)
					mra_pkg::ADDR_BUS_VOLTAGE_RESULT:
						o_reg_rdata <= bus_voltage_result_reg;
					mra_pkg::ADDR_POWER_RESULT:
						o_reg_rdata <= power_result_reg;
					mra_pkg::ADDR_CURRENT_RESULT:
						o_reg_rdata <= current_result_reg;
					mra_pkg::ADDR_CALIBRATION_VALUE:
						o_reg_rdata <= calibration_value_reg;
					mra_pkg::ADDR_ALERT_MASK_FLAGS: begin
						o_reg_rdata <= {mask_reg[15:5],
							alert_function_flag_reg,
							conversion_done_flag_reg,
							math_overflow_flag_reg, mask_reg[1:0]};
					end
					default: o_reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	property p_bus_top_zero;
		bus_voltage_result_reg[15] == 1'b0;
	endproperty
	a_bus_top_zero: assert property (p_bus_top_zero)
		else $error("bus result top bit set");

	property p_cal_top_zero;
		calibration_value_reg[15] == 1'b0;
	endproperty
	a_cal_top_zero: assert property (p_cal_top_zero)
		else $error("calibration top bit set");

	property p_done_after_math;
		i_clk_en && state_reg == ST_IDLE && avg_bus.avg_done ##1
		i_clk_en ##1 i_clk_en ##1 i_clk_en |=> conversion_done_flag_reg;
	endproperty
	a_done_after_math: assert property (p_done_after_math)
		else $error("done flag not set after math");

	property p_read_clears_done;
		i_clk_en && mask_read && state_reg != ST_COMPARE |=>
		!conversion_done_flag_reg;
	endproperty
	a_read_clears_done: assert property (p_read_clears_done)
		else $error("mask read left done flag set");

	property p_polarity;
		i_clk_en |=> o_alert_oe ==
			($past(alert_active) ^ $past(mask_reg[1]));
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("alert drive wrong for polarity");

	property p_ready_alert;
		i_clk_en && mask_reg[10] && conversion_done_flag_reg &&
		!mask_reg[1] |=> o_alert_oe;
	endproperty
	a_ready_alert: assert property (p_ready_alert)
		else $error("ready flag did not raise alert");

	property p_latch_hold;
		i_clk_en && mask_reg[0] && alert_function_flag_reg &&
		!mask_read |=> alert_function_flag_reg;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latched alert flag dropped");

	property p_shunt_over;
		i_clk_en && state_reg == ST_COMPARE && mask_reg[15] &&
		shunt_hold_reg > signed'(i_alert_limit) |=>
		alert_function_flag_reg;
	endproperty
	a_shunt_over: assert property (p_shunt_over)
		else $error("shunt over limit missed");

	property p_priority;
		i_clk_en && state_reg == ST_COMPARE && !mask_reg[0] &&
		mask_reg[15] && shunt_hold_reg <= signed'(i_alert_limit) |=>
		!alert_function_flag_reg;
	endproperty
	a_priority: assert property (p_priority)
		else $error("lower function overrode higher");

	c_conversion: cover property (state_reg == ST_COMPARE ##1
		conversion_done_flag_reg);
	c_latched: cover property (mask_reg[0] && alert_function_flag_reg
		##1 mask_read);
	c_overflow: cover property (math_overflow_flag_reg);
endmodule : mra_result_alert_regs
`default_nettype wire

// ---- testbench/mra_host_model.sv ----
`default_nettype none
// ****************************************
// Host side of the register and sample ports
// ****************************************
module mra_host_model (
	input  wire logic        i_sys_clk,
	output var  logic [7:0]  o_reg_ptr,
	output var  logic        o_reg_wr_en,
	output var  logic        o_reg_rd_en,
	output var  logic [15:0] o_reg_wdata,
	input  wire logic [15:0] i_reg_rdata,
	input  wire logic        i_reg_rvalid,
	output var  logic        o_sample_valid,
	output var  logic [15:0] o_shunt_sample,
	output var  logic [15:0] o_bus_sample
);
	timeunit 1ns;
	timeprecision 1ps;

	logic timed_out;

	initial begin
		o_reg_ptr = 8'h00;
		o_reg_wr_en = 1'b0;
		o_reg_rd_en = 1'b0;
		o_reg_wdata = 16'h0000;
		o_sample_valid = 1'b0;
		o_shunt_sample = 16'h0000;
		o_bus_sample = 16'h0000;
		timed_out = 1'b0;
	end

	// Data is inverted after release so stale values never look valid
	task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d);
		@(posedge i_sys_clk);
		#1;
		o_reg_ptr = ptr;
		o_reg_wdata = d;
		o_reg_wr_en = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_wr_en = 1'b0;
		o_reg_wdata = ~d;
	endtask : write_reg

	// Pointer is held until the answer is seen
	task automatic read_reg(input logic [7:0] ptr, output logic [15:0] d);
		int n;
		@(posedge i_sys_clk);
		#1;
		o_reg_ptr = ptr;
		o_reg_rd_en = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_reg_rd_en = 1'b0;
		n = 0;
		while (i_reg_rvalid !== 1'b1 && n < 3) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		timed_out = (i_reg_rvalid !== 1'b1);
		d = i_reg_rdata;
	endtask : read_reg

	// Spacing of nine cycles covers the whole math and alert pipeline
	task automatic send_sample(input logic [15:0] sh, input logic [15:0] bv);
		@(posedge i_sys_clk);
		#1;
		o_shunt_sample = sh;
		o_bus_sample = bv;
		o_sample_valid = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_sample_valid = 1'b0;
		o_shunt_sample = ~sh;
		o_bus_sample = ~bv;
		repeat (9) @(posedge i_sys_clk);
	endtask : send_sample
endmodule : mra_host_model
`default_nettype wire

// ---- testbench/tb_mra_result_alert_regs.sv ----
`default_nettype none
module tb_mra_result_alert_regs;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, reset_n, cfg_write, cfg_pd, alert_out, alert_oe;
	logic        clk_en, aff_m;
	logic        wr_en, rd_en, rvalid, smp_valid;
	logic [7:0]  ptr;
	logic [15:0] wdata, rdata, shunt, bus_in, alert_limit, mask, cal, w;
	logic [15:0] d, sh, bv;
	logic [3:0]  avg_log2;
	integer      seed;
	int          err_count, samples_checked;
	int          shq[$], bsq[$], ssum, bsum;

	mra_host_model host (
		.i_sys_clk      (sys_clk),
		.o_reg_ptr      (ptr),
		.o_reg_wr_en    (wr_en),
		.o_reg_rd_en    (rd_en),
		.o_reg_wdata    (wdata),
		.i_reg_rdata    (rdata),
		.i_reg_rvalid   (rvalid),
		.o_sample_valid (smp_valid),
		.o_shunt_sample (shunt),
		.o_bus_sample   (bus_in)
	);

	// Alert net has a pull-up; only the open collector pulls it low
	mra_result_alert_regs dut (
		.i_sys_clk       (sys_clk),
		.i_resetn        (reset_n),
		.i_clk_en        (clk_en),
		.i_reg_ptr       (ptr),
		.i_reg_wr_en     (wr_en),
		.i_reg_rd_en     (rd_en),
		.i_reg_wdata     (wdata),
		.o_reg_rdata     (rdata),
		.o_reg_rvalid    (rvalid),
		.i_cfg_write     (cfg_write),
		.i_cfg_powerdown (cfg_pd),
		.i_alert_limit   (alert_limit),
		.i_avg_log2      (avg_log2),
		.i_sample_valid  (smp_valid),
		.i_shunt_sample  (shunt),
		.i_bus_sample    (bus_in),
		.i_alert_pin     (!alert_oe),
		.o_alert_out     (alert_out),
		.o_alert_oe      (alert_oe)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task automatic check(input logic [15:0] got, input logic [15:0] exp,
			input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask : check

	task automatic rd_get(input logic [7:0] p, output logic [15:0] q);
		host.read_reg(p, q);
		if (host.timed_out) begin
			err_count++;
			$display("CHECK FAILED t=%0t no read answer", $time);
			complete_run();
		end
	endtask : rd_get

	task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp,
			input string what);
		logic [15:0] q;
		rd_get(p, q);
		check(q, exp, what);
	endtask : rd_chk

	function automatic logic [15:0] sat16(input longint v);
		if (v > 32767)
			return 16'h7fff;
		if (v < -32768)
			return 16'h8000;
		return v[15:0];
	endfunction : sat16

	// ****************************************
	// Reference model of one conversion
	// ****************************************
	// Math uses the averaged values; the raw sample only feeds the window
	task automatic convert(input logic [15:0] s, input logic [15:0] b,
			input logic [15:0] sa, input logic [15:0] ba);
		longint cr, pr, mag;
		logic [15:0] bus, cur, pwr;
		logic hit, ovf, aff;
		int fn;
		host.send_sample(s, b);
		bus = ba[15] ? mra_pkg::FULL_SCALE_POS : ba;
		cr = (longint'($signed(sa)) * longint'(cal)) >>> 11;
		cur = sat16(cr);
		mag = cur[15] ? -longint'($signed(cur)) : longint'(cur);
		pr = mag * longint'(bus) / 20000;
		// Power result is unsigned, so only a full 16-bit word saturates
		pwr = (pr > 65535) ? 16'hffff : pr[15:0];
		ovf = (cr > 32767) || (cr < -32768) || (pr > 65535);
		fn = 0;
		for (int k = 11; k < 16; k++)
			if (mask[k])
				fn = k;
		case (fn)
			15: hit = $signed(sa) > $signed(alert_limit);
			14: hit = $signed(sa) < $signed(alert_limit);
			13: hit = bus > alert_limit;
			12: hit = bus < alert_limit;
			11: hit = pwr > alert_limit;
			default: hit = 1'b0;
		endcase
		// A latched flag survives a later conversion that raises nothing
		aff = mask[0] ? (aff_m | hit) : hit;
		check({15'h0000, alert_oe},
			{15'h0000, ((aff && fn != 0) | mask[10]) ^ mask[1]},
			"alert");
		check({15'h0000, alert_out}, 16'h0000, "alert out");
		rd_chk(mra_pkg::ADDR_BUS_VOLTAGE_RESULT, bus, "bus");
		rd_chk(mra_pkg::ADDR_CURRENT_RESULT, cur, "current");
		rd_chk(mra_pkg::ADDR_POWER_RESULT, pwr, "power");
		rd_chk(mra_pkg::ADDR_ALERT_MASK_FLAGS, {mask[15:10], 5'h00, aff,
			1'b1, ovf, mask[1:0]}, "flags");
		aff_m = mask[0] ? 1'b0 : hit;
		repeat (2) @(posedge sys_clk);
		#1;
		check({15'h0000, alert_oe}, {15'h0000, (aff_m && fn != 0) ^ mask[1]},
			"alert after read");
	endtask : convert

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 32'hafc49de2;
		err_count = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		cfg_write = 1'b0;
		cfg_pd = 1'b0;
		alert_limit = 16'h0000;
		avg_log2 = 4'h0;
		mask = 16'h0000;
		cal = 16'h0000;
		clk_en = 1'b1;
		aff_m = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		host.write_reg(mra_pkg::ADDR_BUS_VOLTAGE_RESULT, 16'hffff);
		for (logic [7:0] p = 8'h00; p < 8'h08; p++)
			rd_chk(p, 16'h0000, "reset or unmapped");
		// With the enable low neither a write nor a sample may land
		clk_en = 1'b0;
		host.write_reg(mra_pkg::ADDR_CALIBRATION_VALUE, 16'h1234);
		host.send_sample(16'h0100, 16'h0100);
		#1;
		clk_en = 1'b1;
		rd_chk(mra_pkg::ADDR_CALIBRATION_VALUE, mra_pkg::RST_CALIBRATION,
			"frozen cal");
		rd_chk(mra_pkg::ADDR_BUS_VOLTAGE_RESULT, mra_pkg::RST_RESULT,
			"frozen bus");
		for (int i = 0; i < 12; i++) begin
			w = $random(seed);
			if (i < 6)
				w[15:10] = 6'h20 >> i;
			mask = w & mra_pkg::MASK_WR_BITS;
			host.write_reg(mra_pkg::ADDR_ALERT_MASK_FLAGS, w);
			w = $random(seed);
			cal = w & mra_pkg::CAL_WR_BITS;
			host.write_reg(mra_pkg::ADDR_CALIBRATION_VALUE, w);
			rd_chk(mra_pkg::ADDR_CALIBRATION_VALUE, cal, "cal");
			alert_limit = $random(seed);
			sh = $random(seed);
			bv = $random(seed);
			convert(sh, bv, sh, bv);
		end
		// Power-down selection must leave the done flag standing
		for (int k = 0; k < 2; k++) begin
			host.send_sample(16'h0010, 16'h0100);
			@(posedge sys_clk);
			#1;
			cfg_write = 1'b1;
			cfg_pd = (k == 1);
			@(posedge sys_clk);
			#1;
			cfg_write = 1'b0;
			rd_get(mra_pkg::ADDR_ALERT_MASK_FLAGS, d);
			check({15'h0000, d[3]}, {15'h0000, k == 1}, "done");
		end
		avg_log2 = 4'h2;
		sh = 16'h0000;
		bv = 16'h0000;
		ssum = 0;
		bsum = 0;
		for (int k = 0; k < 4; k++) begin
			sh = sh - 16'h0004;
			bv = bv + 16'h0064;
			shq.push_back(int'($signed(sh)));
			bsq.push_back(int'(bv));
			if (k < 3)
				host.send_sample(sh, bv);
		end
		// Window of four: the average is the sum shifted down by two
		while (shq.size() > 0) begin
			ssum += shq.pop_front();
			bsum += bsq.pop_front();
		end
		convert(sh, bv, 16'(ssum >>> 2), 16'(bsum >>> 2));
		reset_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		for (logic [7:0] p = 8'h02; p < 8'h07; p++)
			rd_chk(p, 16'h0000, "after reset");
		check({15'h0000, alert_oe}, 16'h0000, "oe after reset");
		complete_run();
	end
endmodule : tb_mra_result_alert_regs
`default_nettype wire
